// ### design/wkc_defs.vh
`ifndef WKC_DEFS_VH
`define WKC_DEFS_VH

// ****************************************
// idle command parameter positions
// ****************************************
`define WKC_IDLE_LEN 5'd16
`define WKC_IDX_SOURCE 4'h2
`define WKC_IDX_WAKE_PERIOD 4'h9
`define WKC_IDX_UP_THRESH 4'hD
`define WKC_IDX_MAX_SLEEP 4'hF

// ****************************************
// source and event register fields
// ****************************************
`define WKC_RATE_HI 7
`define WKC_RATE_LO 6
`define WKC_BIT_RESERVED 5
`define WKC_BIT_SELECT_PIN 4
`define WKC_BIT_IRQ_PIN 3
`define WKC_BIT_FIELD 2
`define WKC_BIT_TAG 1
`define WKC_BIT_TIMEOUT 0
`define WKC_SRC_WR_MASK 8'hDF
`define WKC_SOURCE_RESET 8'h00
`define WKC_EVENT_RESET 8'h00
`define WKC_WAKE_PERIOD_RESET 8'h00
`define WKC_MAX_SLEEP_RESET 5'h01
`define WKC_SYNC_IDLE 5'h1C

// ****************************************
// register read selectors
// ****************************************
`define WKC_RD_SOURCE 2'h0
`define WKC_RD_EVENT 2'h1
`define WKC_RD_WAKE_PERIOD 2'h2
`define WKC_RD_MAX_SLEEP 2'h3

// ****************************************
// oscillator rates and timing
// ****************************************
`define WKC_RATE_32K 2'h0
`define WKC_RATE_16K 2'h1
`define WKC_RATE_8K 2'h2
`define WKC_RATE_4K 2'h3
`define WKC_REF_OSC_PERIODS 9'd256
`define WKC_REF_LAST 8'hFF

// ****************************************
// idle reply bytes
// ****************************************
`define WKC_REPLY_RESULT 8'h00
`define WKC_REPLY_LENGTH 8'h01
`define WKC_REPLY_LAST 2'h2

`endif

// ### design/wkc_sync2.v
`timescale 1ns/1ns
`include "wkc_defs.vh"

module wkc_sync2
(
  // clock and reset
  input wire core_clk,
  input wire rst_b,
  // asynchronous levels
  input wire [4:0] async_in,
  // synchronised levels
  output reg [4:0] sync_out
);

  reg [4:0] meta_q;

  // first stage feeds only the second stage
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // idle levels: select and irq high, osc high, detectors low
      meta_q <= `WKC_SYNC_IDLE;
      sync_out <= `WKC_SYNC_IDLE;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // wkc_sync2

// ### design/wkc_wake_ctrl.v
`timescale 1ns/1ns
`include "wkc_defs.vh"

// Operation
// - source byte is third idle parameter byte
// - latch rate and sources from idle parameters
// - event register updated on leaving wait
// - event readable by read and reply
// - bits seven six select oscillator rate
// - select pin low wakes when enabled
// - interrupt pin low wakes when enabled
// - detected field wakes when enabled
// - detected tag wakes when enabled
// - timeout wakes and returns to ready
// - timeout is sleeps times period plus one
// - reference period is 256 oscillator periods
// - reply is 00 01 then event
module wkc_wake_ctrl
(
  // clock and reset
  input wire core_clk,
  input wire rst_b,
  // idle command parameters from command decoder
  input wire param_wr,
  input wire [3:0] param_idx,
  input wire [7:0] param_data,
  input wire idle_start,
  // register read command
  input wire rd_req,
  input wire [1:0] rd_sel,
  // device pins and detector levels
  input wire select_b_pin,
  input wire irq_in_b_pin,
  input wire low_freq_osc_pin,
  input wire field_det_in,
  input wire tag_det_in,
  // register read answer
  output reg rd_valid_q,
  output reg [7:0] rd_data_q,
  // idle reply byte stream
  output reg reply_valid_q,
  output reg [7:0] reply_data_q,
  // status
  output reg wait_for_event_state_q,
  output reg [7:0] upper_detect_threshold_q
);

  // ****************************************
  // states
  // ****************************************
  localparam STATE_READY = 2'b00;
  localparam STATE_WAIT = 2'b01;
  localparam STATE_REPLY = 2'b10;

  // ****************************************
  // functions
  // ****************************************
  // base tick count per oscillator period, minus one
  function [2:0] rate_div_last;
    input [1:0] rate;
    begin
      case (rate)
        `WKC_RATE_32K: rate_div_last = 3'h0;
        `WKC_RATE_16K: rate_div_last = 3'h1;
        `WKC_RATE_8K: rate_div_last = 3'h3;
        default: rate_div_last = 3'h7;
      endcase
    end
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [7:0] wake_source_select_q;
  reg [7:0] wake_cause_report_q;
  reg [7:0] wake_period_setting_q;
  reg [4:0] max_sleep_count_q;
  reg osc_prev_q;
  reg [2:0] prescale_q;
  reg [7:0] ref_cnt_q;
  reg [7:0] period_cnt_q;
  reg [4:0] sleep_cnt_q;
  reg [1:0] reply_idx_q;
  wire [4:0] pins_sync;
  wire select_low;
  wire irq_low;
  wire osc_level;
  wire field_seen;
  wire tag_seen;
  wire base_tick;
  wire osc_tick;
  wire ref_last;
  wire period_last;
  wire sleep_last;
  wire timeout_hit;
  wire [4:0] wake_hits;
  wire any_wake;
  wire in_wait;

  // ****************************************
  // pin synchronisation
  // ****************************************
  wkc_sync2 u_sync
  (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .async_in({select_b_pin, irq_in_b_pin, low_freq_osc_pin, field_det_in, tag_det_in}),
    .sync_out(pins_sync)
  );

  assign select_low = ~pins_sync[4];
  assign irq_low = ~pins_sync[3];
  assign osc_level = pins_sync[2];
  assign field_seen = pins_sync[1];
  assign tag_seen = pins_sync[0];
  assign in_wait = (state_q == STATE_WAIT);

  // ****************************************
  // oscillator tick and rate divider
  // ****************************************
  // the pin carries the 32 kHz base; slower rates skip base ticks
  assign base_tick = osc_level & ~osc_prev_q;
  assign osc_tick = base_tick &
    (prescale_q == rate_div_last(wake_source_select_q[`WKC_RATE_HI:`WKC_RATE_LO]));

  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // same as the synchroniser idle level, so no false edge
      osc_prev_q <= 1'b1;
      prescale_q <= 3'h0;
    end
    else
    begin
      osc_prev_q <= osc_level;
      if (!in_wait || osc_tick)
      begin
        prescale_q <= 3'h0;
      end
      else if (base_tick)
      begin
        prescale_q <= prescale_q + 3'h1;
      end
    end
  end

  // ****************************************
  // timeout counting
  // ****************************************
  assign ref_last = (ref_cnt_q == `WKC_REF_LAST);
  assign period_last = (period_cnt_q == wake_period_setting_q);
  assign sleep_last = (sleep_cnt_q == (max_sleep_count_q - 5'h1));
  // a zero max sleep count wraps the counter to 32 sleeps
  assign timeout_hit = osc_tick & ref_last & period_last & sleep_last;

  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ref_cnt_q <= 8'h00;
      period_cnt_q <= 8'h00;
      sleep_cnt_q <= 5'h00;
    end
    else if (!in_wait)
    begin
      ref_cnt_q <= 8'h00;
      period_cnt_q <= 8'h00;
      sleep_cnt_q <= 5'h00;
    end
    else if (osc_tick)
    begin
      ref_cnt_q <= ref_cnt_q + 8'h01;
      if (ref_last)
      begin
        if (period_last)
        begin
          period_cnt_q <= 8'h00;
          sleep_cnt_q <= sleep_cnt_q + 5'h01;
        end
        else
        begin
          period_cnt_q <= period_cnt_q + 8'h01;
        end
      end
    end
  end

  // ****************************************
  // wake sources
  // ****************************************
  assign wake_hits[4] = select_low & wake_source_select_q[`WKC_BIT_SELECT_PIN];
  assign wake_hits[3] = irq_low & wake_source_select_q[`WKC_BIT_IRQ_PIN];
  assign wake_hits[2] = field_seen & wake_source_select_q[`WKC_BIT_FIELD];
  assign wake_hits[1] = tag_seen & wake_source_select_q[`WKC_BIT_TAG];
  assign wake_hits[0] = timeout_hit & wake_source_select_q[`WKC_BIT_TIMEOUT];
  assign any_wake = in_wait & (|wake_hits);

  // ****************************************
  // state machine
  // ****************************************
  always @*
  begin
    state_d = state_q;
    case (state_q)
      STATE_READY:
      begin
        if (idle_start)
        begin
          state_d = STATE_WAIT;
        end
      end
      STATE_WAIT:
      begin
        if (any_wake)
        begin
          state_d = STATE_REPLY;
        end
      end
      STATE_REPLY:
      begin
        if (reply_idx_q == `WKC_REPLY_LAST)
        begin
          state_d = STATE_READY;
        end
      end
      default:
      begin
        state_d = STATE_READY;
      end
    endcase
  end

  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= STATE_READY;
      wait_for_event_state_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      wait_for_event_state_q <= (state_d == STATE_WAIT);
    end
  end

  // ****************************************
  // parameter registers
  // ****************************************
  // parameters are frozen while waiting so the timeout stays coherent
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wake_source_select_q <= `WKC_SOURCE_RESET;
      wake_period_setting_q <= `WKC_WAKE_PERIOD_RESET;
      max_sleep_count_q <= `WKC_MAX_SLEEP_RESET;
      upper_detect_threshold_q <= 8'h00;
    end
    else if (param_wr && (state_q == STATE_READY))
    begin
      case (param_idx)
        `WKC_IDX_SOURCE:
        begin
          wake_source_select_q <= param_data & `WKC_SRC_WR_MASK;
        end
        `WKC_IDX_WAKE_PERIOD:
        begin
          wake_period_setting_q <= param_data;
        end
        `WKC_IDX_UP_THRESH:
        begin
          upper_detect_threshold_q <= param_data;
        end
        `WKC_IDX_MAX_SLEEP:
        begin
          max_sleep_count_q <= param_data[4:0];
        end
        default:
        begin
          max_sleep_count_q <= max_sleep_count_q;
        end
      endcase
    end
  end

  // ****************************************
  // wake cause report
  // ****************************************
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wake_cause_report_q <= `WKC_EVENT_RESET;
    end
    else if (any_wake)
    begin
      // all causes present in the leaving cycle are reported together
      wake_cause_report_q <= {wake_source_select_q[`WKC_RATE_HI:`WKC_RATE_LO], 1'b0,
        wake_hits};
    end
  end

  // ****************************************
  // idle reply
  // ****************************************
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reply_idx_q <= 2'h0;
      reply_valid_q <= 1'b0;
      reply_data_q <= 8'h00;
    end
    else if (state_q == STATE_REPLY)
    begin
      reply_idx_q <= reply_idx_q + 2'h1;
      reply_valid_q <= 1'b1;
      case (reply_idx_q)
        2'h0: reply_data_q <= `WKC_REPLY_RESULT;
        2'h1: reply_data_q <= `WKC_REPLY_LENGTH;
        default: reply_data_q <= wake_cause_report_q;
      endcase
    end
    else
    begin
      reply_idx_q <= 2'h0;
      reply_valid_q <= 1'b0;
      reply_data_q <= 8'h00;
    end
  end

  // ****************************************
  // register read
  // ****************************************
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_valid_q <= 1'b0;
      rd_data_q <= 8'h00;
    end
    else
    begin
      rd_valid_q <= rd_req;
      if (rd_req)
      begin
        case (rd_sel)
          `WKC_RD_SOURCE: rd_data_q <= wake_source_select_q;
          `WKC_RD_EVENT: rd_data_q <= wake_cause_report_q;
          `WKC_RD_WAKE_PERIOD: rd_data_q <= wake_period_setting_q;
          default: rd_data_q <= {3'h0, max_sleep_count_q};
        endcase
      end
    end
  end

endmodule // wkc_wake_ctrl

// ### bench/wkc_wake_ctrl_asserts.sv
`timescale 1ns/1ns

// ****************************************
// port checks for the wake control
// ****************************************
module wkc_wake_ctrl_asserts
(
  // clock and reset
  input logic core_clk,
  input logic rst_b,
  // requests
  input logic rd_req,
  input logic idle_start,
  // answers
  input logic rd_valid_q,
  input logic [7:0] rd_data_q,
  input logic reply_valid_q,
  input logic [7:0] reply_data_q,
  input logic wait_for_event_state_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // reply walks 00, 01, event, then drops
  sequence s_reply_tail;
    reply_valid_q && reply_data_q == 8'h01 ##1 reply_valid_q ##1 !reply_valid_q;
  endsequence
  a_read_answer: assert property (rd_req |=> rd_valid_q)
    else $error("read not answered");
  a_read_cause: assert property (rd_valid_q |-> $past(rd_req))
    else $error("read answer without request");
  a_read_hold: assert property (!rd_valid_q |-> $stable(rd_data_q))
    else $error("read data moved");
  a_idle_enter: assert property ((idle_start && !wait_for_event_state_q
    && !$past(wait_for_event_state_q) && !reply_valid_q && !$past(reply_valid_q))
    |=> wait_for_event_state_q) else $error("idle not entered");
  a_reply_order: assert property ($rose(reply_valid_q) |->
    reply_data_q == 8'h00 ##1 s_reply_tail) else $error("reply order");
  a_wake_reply: assert property ($fell(wait_for_event_state_q) |=> $rose(reply_valid_q))
    else $error("no reply after wake");
  a_reply_cause: assert property ($rose(reply_valid_q) |->
    $past(wait_for_event_state_q, 2) && !$past(wait_for_event_state_q))
    else $error("reply without wake");
  a_reply_quiet: assert property (!reply_valid_q |-> reply_data_q == 8'h00)
    else $error("reply data outside reply");
  a_wait_silent: assert property (wait_for_event_state_q |-> !reply_valid_q)
    else $error("reply while waiting");
endmodule // wkc_wake_ctrl_asserts

bind wkc_wake_ctrl wkc_wake_ctrl_asserts u_chk (.core_clk(core_clk), .rst_b(rst_b),
  .rd_req(rd_req), .idle_start(idle_start), .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q),
  .reply_valid_q(reply_valid_q), .reply_data_q(reply_data_q),
  .wait_for_event_state_q(wait_for_event_state_q));

// ### bench/wkc_env_model.sv
`timescale 1ns/1ns

// ****************************************
// pins and detectors around the device
// ****************************************
module wkc_env_model
(
  // cause requests: select, irq, field, tag
  input logic [3:0] cause_req,
  // device pins and detector levels
  output logic select_b_pin,
  output logic irq_in_b_pin,
  output logic low_freq_osc_pin,
  output logic field_det_in,
  output logic tag_det_in
);
  // free running, 300 ns, offset so it never meets a core edge
  initial
  begin
    low_freq_osc_pin = 1'b1;
    #37;
    forever #150 low_freq_osc_pin = ~low_freq_osc_pin;
  end
  // pulled-up pins go high when released
  assign select_b_pin = ~cause_req[3];
  assign irq_in_b_pin = ~cause_req[2];
  assign field_det_in = cause_req[1];
  assign tag_det_in = cause_req[0];
endmodule // wkc_env_model

// ### bench/wkc_wake_ctrl_test.sv
`timescale 1ns/1ns
`include "wkc_defs.vh"

// ****************************************
// wake control testbench
// ****************************************
module wkc_wake_ctrl_test;
  logic core_clk, rst_b, param_wr, idle_start, rd_req, rd_valid_q, reply_valid_q;
  logic select_b_pin, irq_in_b_pin, low_freq_osc_pin, field_det_in, tag_det_in;
  logic wait_for_event_state_q;
  logic [3:0] param_idx, cause_req;
  logic [7:0] param_data, rd_data_q, reply_data_q, upper_detect_threshold_q, per;
  logic [1:0] rd_sel, r;
  logic [4:0] ms;
  int n_errors, compares, b, cyc, exp_cyc, tol;

  wkc_env_model u_env (.cause_req(cause_req), .select_b_pin(select_b_pin),
    .irq_in_b_pin(irq_in_b_pin), .low_freq_osc_pin(low_freq_osc_pin),
    .field_det_in(field_det_in), .tag_det_in(tag_det_in));
  wkc_wake_ctrl u_dut (.core_clk(core_clk), .rst_b(rst_b), .param_wr(param_wr),
    .param_idx(param_idx), .param_data(param_data), .idle_start(idle_start),
    .rd_req(rd_req), .rd_sel(rd_sel), .select_b_pin(select_b_pin),
    .irq_in_b_pin(irq_in_b_pin), .low_freq_osc_pin(low_freq_osc_pin),
    .field_det_in(field_det_in), .tag_det_in(tag_det_in), .rd_valid_q(rd_valid_q),
    .rd_data_q(rd_data_q), .reply_valid_q(reply_valid_q), .reply_data_q(reply_data_q),
    .wait_for_event_state_q(wait_for_event_state_q),
    .upper_detect_threshold_q(upper_detect_threshold_q));

  task automatic print_verdict;
  begin
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
  begin
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  end
  endtask

  task automatic wr_param(input logic [3:0] idx, input logic [7:0] data);
  begin
    @(posedge core_clk);
    param_wr <= 1'b1;
    param_idx <= idx;
    param_data <= data;
    @(posedge core_clk);
    param_wr <= 1'b0;
  end
  endtask

  task automatic rd_reg(input logic [1:0] sel, input logic [7:0] exp);
  begin
    @(posedge core_clk);
    rd_req <= 1'b1;
    rd_sel <= sel;
    @(posedge core_clk);
    rd_req <= 1'b0;
    #1;
    check({7'h00, rd_valid_q}, 8'h01, "read valid");
    check(rd_data_q, exp, "read data");
  end
  endtask

  task automatic go_idle(input logic [7:0] src, input logic [7:0] p, input logic [4:0] m);
  begin
    wr_param(`WKC_IDX_SOURCE, src);
    wr_param(`WKC_IDX_WAKE_PERIOD, p);
    wr_param(`WKC_IDX_MAX_SLEEP, {3'h0, m});
    @(posedge core_clk);
    idle_start <= 1'b1;
    @(posedge core_clk);
    idle_start <= 1'b0;
    #1;
    check({7'h00, wait_for_event_state_q}, 8'h01, "wait entry");
  end
  endtask

  // wait for the wake, then take the three reply bytes
  task automatic await_wake(input logic [7:0] ev, input int bound, output int n);
    int i;
  begin
    n = 0;
    i = 0;
    while (wait_for_event_state_q === 1'b1 && n < bound)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= bound)
    begin
      n_errors++;
      $display("ERROR %0t no wake", $time);
      print_verdict;
    end
    while (reply_valid_q !== 1'b1 && i < 4)
    begin
      @(posedge core_clk);
      #1;
      i++;
    end
    check({7'h00, reply_valid_q}, 8'h01, "reply valid");
    check(reply_data_q, `WKC_REPLY_RESULT, "reply byte 0");
    @(posedge core_clk);
    #1;
    check(reply_data_q, `WKC_REPLY_LENGTH, "reply byte 1");
    @(posedge core_clk);
    #1;
    check(reply_data_q, ev, "reply event");
  end
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  initial
  begin
    {rst_b, param_wr, idle_start, rd_req} = 4'h0;
    {param_idx, cause_req, param_data, rd_sel} = 18'h0;
    n_errors = 0;
    compares = 0;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    rd_reg(`WKC_RD_SOURCE, `WKC_SOURCE_RESET);
    rd_reg(`WKC_RD_EVENT, `WKC_EVENT_RESET);
    rd_reg(`WKC_RD_MAX_SLEEP, 8'h01);
    wr_param(`WKC_IDX_SOURCE, 8'hDF);
    rd_reg(`WKC_RD_SOURCE, 8'hDF);
    wr_param(`WKC_IDX_UP_THRESH, 8'h7C);
    #1 check(upper_detect_threshold_q, 8'h7C, "threshold");
    // one pin cause per pass, others active but not enabled
    for (b = 0; b < 4; b++)
    begin
      go_idle({b[1:0] ^ 2'h3, 6'h10 >> b}, 8'h00, 5'h01);
      wr_param(`WKC_IDX_SOURCE, 8'h00);
      cause_req <= ~(4'h8 >> b);
      repeat (20) @(posedge core_clk);
      #1 check({7'h00, wait_for_event_state_q}, 8'h01, "woke early");
      @(posedge core_clk);
      cause_req <= 4'hF;
      await_wake({b[1:0] ^ 2'h3, 6'h10 >> b}, 20, cyc);
      @(posedge core_clk);
      cause_req <= 4'h0;
      rd_reg(`WKC_RD_EVENT, {b[1:0] ^ 2'h3, 6'h10 >> b});
      rd_reg(`WKC_RD_SOURCE, {b[1:0] ^ 2'h3, 6'h10 >> b});
    end
    // timeout at every rate, then a longer count
    for (b = 0; b < 5; b++)
    begin
      r = b[1:0];
      ms = (b == 4) ? 5'h02 : 5'h01;
      per = (b == 4) ? 8'h01 : 8'h00;
      exp_cyc = (768 * ms * (per + 1)) << r;
      tol = 10 + (3 << r);
      go_idle({r, 6'h03}, per, ms);
      await_wake({r, 6'h01}, 7000, cyc);
      compares++;
      if (cyc < exp_cyc - tol || cyc > exp_cyc + tol)
      begin
        n_errors++;
        $display("ERROR %0t timeout took %0d cycles, exp %0d", $time, cyc, exp_cyc);
      end
      rd_reg(`WKC_RD_WAKE_PERIOD, per);
    end
    // reset in mid wait
    go_idle(8'h08, 8'h00, 5'h01);
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    #1 check({7'h00, wait_for_event_state_q}, 8'h00, "wait after reset");
    rd_reg(`WKC_RD_SOURCE, `WKC_SOURCE_RESET);
    print_verdict;
  end
endmodule // wkc_wake_ctrl_test
